// ===== logic/bit_sync.sv
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1_reg <= RST_VAL;
      sync_o     <= RST_VAL;
    end else begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule

// ===== logic/parallel_flash_program_lock.sv
// Parallel programming, verify, erase and lock protection for the code flash array.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module parallel_flash_program_lock #(
  parameter int unsigned WRITE_CYCLES = flash_lock_pkg::WRITE_CYCLES,
  parameter int unsigned ERASE_CYCLES = flash_lock_pkg::ERASE_CYCLES,
  parameter logic [7:0]  SIG_BYTE_0   = 8'hA5, // Arbitrary value.
  parameter logic [7:0]  SIG_BYTE_1   = 8'h3C, // Arbitrary value.
  parameter logic [7:0]  SIG_BYTE_2   = 8'h0F  // Arbitrary value.
) (
  input  wire logic                                  sys_clk_i,
  input  wire logic                                  nrst_i,
  input  wire logic [flash_lock_pkg::ADDR_W-1:0]     addr_pin_i,
  input  wire logic [flash_lock_pkg::DATA_W-1:0]     data_pin_i,
  output logic      [flash_lock_pkg::DATA_W-1:0]     data_pin_o,
  output logic                                       data_pin_oe_n_o,
  input  wire logic                                  ctrl_sel_a_i,
  input  wire logic                                  ctrl_sel_b_i,
  input  wire logic                                  ctrl_sel_c_i,
  input  wire logic                                  signature_select_a_i,
  input  wire logic                                  signature_select_b_i,
  input  wire logic                                  latch_program_strobe_i,
  input  wire logic                                  prog_voltage_high_i,
  input  wire logic                                  external_access_pin_i,
  output logic                                       busy_output_pin_o,
  output logic                                       table_read_block_o,
  output logic                                       external_exec_block_o,
  output logic                                       external_access_eff_o,
  input  wire logic [flash_lock_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                           reg_wdata_i,
  input  wire logic                                  reg_wr_i,
  input  wire logic                                  reg_rd_i,
  output logic      [31:0]                           reg_rdata_o
);

  localparam int SYNC_W = 28;
  localparam flash_lock_pkg::timer_t WRITE_LAST = flash_lock_pkg::timer_t'(WRITE_CYCLES - 1);
  localparam flash_lock_pkg::timer_t ERASE_LAST = flash_lock_pkg::timer_t'(ERASE_CYCLES - 1);
  localparam flash_lock_pkg::timer_t DEPTH_T    = flash_lock_pkg::timer_t'(flash_lock_pkg::ARRAY_DEPTH);

  function automatic logic [1:0] lock_level(input logic [2:0] f);
    lock_level = !f[0] ? 2'h0 : (!f[1] ? 2'h1 : (!f[2] ? 2'h2 : 2'h3));
  endfunction

  // Pin synchronisers; the strobe idles high so it resets high.
  logic [SYNC_W-1:0] sync_bus;
  bit_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (28'h0000004)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({addr_pin_i, data_pin_i, ctrl_sel_a_i, ctrl_sel_b_i, ctrl_sel_c_i, signature_select_a_i,
                 signature_select_b_i, latch_program_strobe_i, prog_voltage_high_i, external_access_pin_i}),
    .sync_o    (sync_bus)
  );

  wire flash_lock_pkg::addr_t      s_addr   = sync_bus[27:16];
  wire flash_lock_pkg::byte_t      s_data   = sync_bus[15:8];
  wire flash_lock_pkg::prog_mode_t s_mode   = flash_lock_pkg::prog_mode_t'(sync_bus[7:3]);
  wire logic                       s_strobe = sync_bus[2];
  wire logic                       s_vpp    = sync_bus[1];
  wire logic                       s_ea     = sync_bus[0];

  flash_lock_pkg::byte_t      mem [flash_lock_pkg::ARRAY_DEPTH];
  logic [2:0]                 fuse_reg = 3'h0;
  flash_lock_pkg::seq_state_t state_reg;
  flash_lock_pkg::seq_state_t state_next;
  flash_lock_pkg::timer_t     timer_reg;
  flash_lock_pkg::timer_t     timer_next;
  flash_lock_pkg::prog_mode_t op_reg;
  flash_lock_pkg::addr_t      wr_addr_reg;
  flash_lock_pkg::byte_t      wr_data_reg;
  flash_lock_pkg::addr_t      raddr_reg;
  flash_lock_pkg::byte_t      data_next;
  logic                       strobe_d_reg;
  logic [1:0]                 start_cnt_reg;
  logic                       ea_latched_reg;
  logic [31:0]                rdata_next;
  logic                       read_active;

  // Protection decode.
  wire logic [1:0] level      = lock_level(fuse_reg);
  wire logic       verify_ok  = !fuse_reg[0] && !fuse_reg[1];
  wire logic       prog_block = fuse_reg[0];

  // Strobe handling; a strobe without programming voltage starts nothing.
  wire logic strobe_rise = s_strobe && !strobe_d_reg;
  wire logic strobe_ok   = strobe_rise && s_vpp && state_reg == flash_lock_pkg::SEQ_IDLE;
  wire logic start_code  = strobe_ok && s_mode == flash_lock_pkg::MODE_WRITE_CODE && !prog_block;
  wire logic start_fuse  = strobe_ok && (s_mode == flash_lock_pkg::MODE_WRITE_FUSE_A ||
                                         s_mode == flash_lock_pkg::MODE_WRITE_FUSE_B ||
                                         s_mode == flash_lock_pkg::MODE_WRITE_FUSE_C);
  wire logic sw_erase    = reg_wr_i && reg_addr_i == flash_lock_pkg::REG_CTRL &&
                           reg_wdata_i[flash_lock_pkg::CTRL_ERASE_BIT] &&
                           state_reg == flash_lock_pkg::SEQ_IDLE;
  wire logic start_erase = (strobe_ok && s_mode == flash_lock_pkg::MODE_CHIP_ERASE) || sw_erase;

  wire logic write_done  = state_reg == flash_lock_pkg::SEQ_WRITE && timer_reg == WRITE_LAST;
  wire logic erase_done  = state_reg == flash_lock_pkg::SEQ_ERASE && timer_reg == ERASE_LAST;
  wire logic erasing     = state_reg == flash_lock_pkg::SEQ_ERASE;
  wire logic erase_wr    = erasing && timer_reg < DEPTH_T;
  wire logic code_commit = write_done && op_reg == flash_lock_pkg::MODE_WRITE_CODE;
  wire logic mem_we      = code_commit || erase_wr;
  wire flash_lock_pkg::addr_t mem_waddr = erase_wr ? timer_reg[flash_lock_pkg::ADDR_W-1:0] : wr_addr_reg;
  wire flash_lock_pkg::byte_t mem_wdata = erase_wr ? flash_lock_pkg::ERASED_BYTE : wr_data_reg;
  wire flash_lock_pkg::byte_t pin_rd    = mem[s_addr];
  wire flash_lock_pkg::byte_t bus_rd    = mem[raddr_reg];
  wire logic poll_hit    = state_reg == flash_lock_pkg::SEQ_WRITE &&
                           op_reg == flash_lock_pkg::MODE_WRITE_CODE && s_addr == wr_addr_reg;

  // Sequencer: one self-timed byte or fuse write, or a whole-array erase.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg + flash_lock_pkg::timer_t'(1);
    unique case (state_reg)
      flash_lock_pkg::SEQ_IDLE: begin
        timer_next = '0;
        if (start_erase) begin
          state_next = flash_lock_pkg::SEQ_ERASE;
        end else if (start_code || start_fuse) begin
          state_next = flash_lock_pkg::SEQ_WRITE;
        end
      end
      flash_lock_pkg::SEQ_WRITE: begin
        if (write_done) begin
          state_next = flash_lock_pkg::SEQ_IDLE;
        end
      end
      flash_lock_pkg::SEQ_ERASE: begin
        if (erase_done) begin
          state_next = flash_lock_pkg::SEQ_IDLE;
        end
      end
      default: begin
        state_next = flash_lock_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg    <= flash_lock_pkg::SEQ_IDLE;
      timer_reg    <= '0;
      op_reg       <= flash_lock_pkg::MODE_READ_SIG;
      wr_addr_reg  <= '0;
      wr_data_reg  <= '0;
      strobe_d_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      strobe_d_reg <= s_strobe;
      if (start_code || start_fuse) begin
        op_reg      <= s_mode;
        wr_addr_reg <= s_addr;
        wr_data_reg <= s_data;
      end
    end
  end

  // Array and fuses are non-volatile, so reset leaves them alone.
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (erase_done) begin
      fuse_reg <= 3'h0;
    end else if (write_done) begin
      if (op_reg == flash_lock_pkg::MODE_WRITE_FUSE_A) fuse_reg[0] <= 1'b1;
      if (op_reg == flash_lock_pkg::MODE_WRITE_FUSE_B) fuse_reg[1] <= 1'b1;
      if (op_reg == flash_lock_pkg::MODE_WRITE_FUSE_C) fuse_reg[2] <= 1'b1;
    end
  end

  // Pin read path: code verify with polling, fuse read-back and signature.
  always_comb begin
    data_next   = flash_lock_pkg::BLOCKED_BYTE;
    read_active = !s_vpp;
    unique case (s_mode)
      flash_lock_pkg::MODE_READ_CODE: begin
        if (poll_hit) begin
          data_next = {~wr_data_reg[7], pin_rd[6:0]};
        end else if (verify_ok) begin
          data_next = pin_rd;
        end
      end
      flash_lock_pkg::MODE_READ_FUSES: begin
        data_next = '0;
        data_next[flash_lock_pkg::LOCK_READ_LSB +: 3] = fuse_reg;
      end
      flash_lock_pkg::MODE_READ_SIG: begin
        if (s_addr == flash_lock_pkg::SIG_ADDR_0) data_next = SIG_BYTE_0;
        if (s_addr == flash_lock_pkg::SIG_ADDR_1) data_next = SIG_BYTE_1;
        if (s_addr == flash_lock_pkg::SIG_ADDR_2) data_next = SIG_BYTE_2;
      end
      default: begin
        read_active = 1'b0;
      end
    endcase
  end

  // With lock fuse A set, the external-access level is caught once the synchronisers have settled after reset.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_cnt_reg  <= 2'h0;
      ea_latched_reg <= 1'b0;
    end else begin
      if (start_cnt_reg != 2'h3) start_cnt_reg <= start_cnt_reg + 2'h1;
      if (start_cnt_reg == flash_lock_pkg::EA_SAMPLE_CYCLE && fuse_reg[0]) begin
        ea_latched_reg <= s_ea;
      end
    end
  end

  // Register bus read mux.
  always_comb begin
    rdata_next = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        flash_lock_pkg::REG_STATUS: begin
          rdata_next[flash_lock_pkg::STAT_BUSY_BIT]        = state_reg != flash_lock_pkg::SEQ_IDLE;
          rdata_next[flash_lock_pkg::STAT_ERASE_BIT]       = erasing;
          rdata_next[flash_lock_pkg::STAT_FUSE_LSB +: 3]   = fuse_reg;
          rdata_next[flash_lock_pkg::STAT_LEVEL_LSB +: 2]  = level;
          rdata_next[flash_lock_pkg::STAT_EA_BIT]          = ea_latched_reg;
        end
        flash_lock_pkg::REG_RADDR: begin
          rdata_next[flash_lock_pkg::ADDR_W-1:0] = raddr_reg;
        end
        flash_lock_pkg::REG_RDATA: begin
          if (erasing) begin
            rdata_next[7:0] = flash_lock_pkg::ERASE_READ_BYTE;
          end else begin
            rdata_next[7:0] = verify_ok ? bus_rd : flash_lock_pkg::BLOCKED_BYTE;
          end
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      raddr_reg             <= '0;
      reg_rdata_o           <= '0;
      data_pin_o            <= '0;
      data_pin_oe_n_o       <= 1'b1;
      busy_output_pin_o     <= 1'b1;
      table_read_block_o    <= 1'b0;
      external_exec_block_o <= 1'b0;
      external_access_eff_o <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == flash_lock_pkg::REG_RADDR) begin
        raddr_reg <= reg_wdata_i[flash_lock_pkg::ADDR_W-1:0];
      end
      reg_rdata_o           <= rdata_next;
      data_pin_o            <= data_next;
      data_pin_oe_n_o       <= !read_active;
      busy_output_pin_o     <= state_next == flash_lock_pkg::SEQ_IDLE;
      table_read_block_o    <= level != 2'h0;
      external_exec_block_o <= level == 2'h3;
      external_access_eff_o <= fuse_reg[0] ? ea_latched_reg : s_ea;
    end
  end

  chk_busy_after_strobe: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (start_code || start_fuse) |-> ##1 (!busy_output_pin_o [*4]))
    else $error("busy pin not low after accepted strobe");

  chk_busy_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_reg == flash_lock_pkg::SEQ_WRITE) |-> timer_reg <= WRITE_LAST && !busy_output_pin_o)
    else $error("byte write ran past its time");

  chk_no_prog_locked: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (strobe_ok && s_mode == flash_lock_pkg::MODE_WRITE_CODE && fuse_reg[0]) |=> state_reg == flash_lock_pkg::SEQ_IDLE)
    else $error("code write accepted while locked");

  chk_no_vpp_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (strobe_rise && !s_vpp && state_reg == flash_lock_pkg::SEQ_IDLE && !sw_erase) |=> busy_output_pin_o)
    else $error("strobe without program voltage was taken");

  chk_verify_blocked: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (s_mode == flash_lock_pkg::MODE_READ_CODE && !s_vpp && !poll_hit && (fuse_reg[0] || fuse_reg[1]))
    |=> data_pin_o == flash_lock_pkg::BLOCKED_BYTE)
    else $error("code byte returned while verify is locked");

  chk_poll_inverted: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (poll_hit && s_mode == flash_lock_pkg::MODE_READ_CODE && !s_vpp) |=> data_pin_o[7] != $past(wr_data_reg[7]))
    else $error("polling bit not inverted during write");

  chk_fuse_readback: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (s_mode == flash_lock_pkg::MODE_READ_FUSES && !s_vpp)
    |=> data_pin_o[flash_lock_pkg::LOCK_READ_LSB +: 3] == $past(fuse_reg) && !data_pin_oe_n_o)
    else $error("fuse read-back wrong");

  chk_erase_reads_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (erasing && reg_rd_i && reg_addr_i == flash_lock_pkg::REG_RDATA) |=> reg_rdata_o == 32'h0)
    else $error("read during erase not zero");

  chk_ea_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (start_cnt_reg == 2'h3 && fuse_reg[0]) |=> $stable(ea_latched_reg) && external_access_eff_o == $past(ea_latched_reg))
    else $error("latched external access changed");

  chk_exec_block: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (&fuse_reg) |=> external_exec_block_o && table_read_block_o)
    else $error("full lock does not block execution");

endmodule

// ===== pkg/flash_lock_pkg.sv
// Constants, types and register map for the flash programming and lock block.
package flash_lock_pkg;

  // Clock rate and self-timed operation lengths.
  localparam int CLK_MHZ        = 125;
  localparam int CLK_KHZ        = 125000;
  localparam int WRITE_TIME_US  = 50;
  localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_TIME_MS  = 500;
  localparam int ERASE_CYCLES   = ERASE_TIME_MS * CLK_KHZ;

  // Array geometry.
  localparam int ADDR_W         = 12;
  localparam int DATA_W         = 8;
  localparam int ARRAY_DEPTH    = 4096;
  localparam int TIMER_W        = 26;

  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [DATA_W-1:0]  byte_t;
  typedef logic [TIMER_W-1:0] timer_t;

  localparam byte_t ERASED_BYTE     = 8'hFF;
  localparam byte_t BLOCKED_BYTE    = 8'hFF;
  localparam byte_t ERASE_READ_BYTE = 8'h00;

  // Lock fuse read-back places the three fuses from this data bit upward.
  localparam int LOCK_READ_LSB  = 2;

  // Signature locations.
  localparam addr_t SIG_ADDR_0  = 12'h000;
  localparam addr_t SIG_ADDR_1  = 12'h100;
  localparam addr_t SIG_ADDR_2  = 12'h200;

  // Startup cycle on which the external-access level is latched.
  localparam logic [1:0] EA_SAMPLE_CYCLE = 2'h2;

  // Register map (byte addresses) and field positions.
  localparam int REG_ADDR_W     = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RADDR  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam int CTRL_ERASE_BIT  = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_ERASE_BIT  = 1;
  localparam int STAT_FUSE_LSB   = 2;
  localparam int STAT_LEVEL_LSB  = 5;
  localparam int STAT_EA_BIT     = 7;

  // Control pin combinations, bits ordered {sel_a, sel_b, sel_c, signature_select_a, signature_select_b}.
  typedef enum logic [4:0] {
    MODE_READ_SIG     = 5'h00,
    MODE_READ_CODE    = 5'h03,
    MODE_WRITE_CODE   = 5'h0F,
    MODE_CHIP_ERASE   = 5'h14,
    MODE_WRITE_FUSE_C = 5'h16,
    MODE_READ_FUSES   = 5'h1A,
    MODE_WRITE_FUSE_B = 5'h1C,
    MODE_WRITE_FUSE_A = 5'h1F
  } prog_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_WRITE = 2'b01,
    SEQ_ERASE = 2'b10
  } seq_state_t;

endpackage

// ===== tb/flash_programmer_model.sv
// Behavioural parallel programmer that drives the device's programming pins.
`timescale 1ns/1ps
module flash_programmer_model (
  input  wire logic        sys_clk_i,
  input  wire logic        busy_i,
  input  wire logic [7:0]  rd_i,
  output logic      [11:0] addr_o,
  output logic      [7:0]  data_o,
  output logic      [4:0]  mode_o,
  output logic             strobe_o,
  output logic             vpp_o
);
  initial begin
    addr_o = 12'h000;
    data_o = 8'h00;
    mode_o = flash_lock_pkg::MODE_READ_CODE;
    strobe_o = 1'b1;
    vpp_o = 1'b0;
  end

  // One strobed operation; n counts busy cycles and poll holds a read taken mid-operation.
  task automatic op(input logic [4:0] m, input logic [11:0] a, input logic [7:0] d, input logic hv,
                    output int n, output logic [7:0] poll);
    n = 0;
    poll = 8'h00;
    @(posedge sys_clk_i) addr_o <= a;
    @(posedge sys_clk_i) data_o <= d;
    @(posedge sys_clk_i) mode_o <= m;
    @(posedge sys_clk_i) vpp_o <= hv;
    @(posedge sys_clk_i) strobe_o <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    strobe_o <= 1'b1;
    for (int i = 0; i < 8 && busy_i; i++) @(posedge sys_clk_i);
    if (!busy_i) begin
      vpp_o <= 1'b0;
      data_o <= ~d;
      mode_o <= flash_lock_pkg::MODE_READ_CODE;
      while (!busy_i && n < 5000) begin
        @(posedge sys_clk_i);
        n++;
        if (n == 6) poll = rd_i;
      end
    end
    vpp_o <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] m, input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    vpp_o <= 1'b0;
    mode_o <= m;
    addr_o <= a;
    repeat (4) @(posedge sys_clk_i);
    d = rd_i;
  endtask
endmodule

// ===== tb/parallel_flash_program_lock_bench.sv
// Self-checking bench for the flash programming and lock block.
`timescale 1ns/1ps
module parallel_flash_program_lock_bench;
  localparam int WC = 20;
  localparam int EC = 4200;
  localparam logic [7:0] SIG [3] = '{8'h5A, 8'hC3, 8'h96}; // Arbitrary values.
  flash_lock_pkg::prog_mode_t fm [3] = '{flash_lock_pkg::MODE_WRITE_FUSE_A,
    flash_lock_pkg::MODE_WRITE_FUSE_B, flash_lock_pkg::MODE_WRITE_FUSE_C};
  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        ea        = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata, w;
  logic [11:0] addr, ad;
  logic [7:0]  wdat, dout, rdat, poll, dt, d0;
  logic [4:0]  mode, le;
  logic        strobe, vpp, busy, oe_n, tblk, xblk, ea_eff;
  int          errors = 0, n_checks = 0, n;

  always #4 sys_clk_i = ~sys_clk_i;

  flash_programmer_model prog (.sys_clk_i(sys_clk_i), .busy_i(busy), .rd_i(dout), .addr_o(addr),
    .data_o(wdat), .mode_o(mode), .strobe_o(strobe), .vpp_o(vpp));
  parallel_flash_program_lock #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC), .SIG_BYTE_0(SIG[0]),
    .SIG_BYTE_1(SIG[1]), .SIG_BYTE_2(SIG[2])) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .addr_pin_i(addr), .data_pin_i(wdat), .data_pin_o(dout), .data_pin_oe_n_o(oe_n),
    .ctrl_sel_a_i(mode[4]), .ctrl_sel_b_i(mode[3]), .ctrl_sel_c_i(mode[2]), .signature_select_a_i(mode[1]),
    .signature_select_b_i(mode[0]), .latch_program_strobe_i(strobe), .prog_voltage_high_i(vpp),
    .external_access_pin_i(ea), .busy_output_pin_o(busy), .table_read_block_o(tblk),
    .external_exec_block_o(xblk), .external_access_eff_o(ea_eff), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

  // Expected {level, fuses C B A} after k+1 fuse writes in A, B, C order.
  function automatic logic [4:0] lock_exp(input int k);
    return {2'(k + 1), 3'((2 << k) - 1)};
  endfunction

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g); cmp({31'h0, e}, {31'h0, g}); endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g); cmp({24'h0, e}, {24'h0, g}); endtask
  task automatic chk32(input logic [31:0] e, input logic [31:0] g); cmp(e, g); endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd <= 1'b0;
    @(posedge sys_clk_i);
    d = reg_rdata;
  endtask
  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'h33b0d036));
    do_reset();
    chk1(1'b1, busy);
    chk1(1'b0, tblk);
    chk1(1'b0, xblk);
    // Location zero is wiped on the first erase cycle, so a pin read mid-erase already shows the erased byte.
    prog.op(flash_lock_pkg::MODE_CHIP_ERASE, 12'h000, 8'h00, 1'b1, n, poll);
    chk1(1'b1, n >= EC - 1 && n <= EC + 1);
    chk8(8'hFF, poll);
    for (int i = 0; i < 3; i++) begin
      prog.rd(flash_lock_pkg::MODE_READ_CODE, 12'($urandom), rdat);
      chk8(8'hFF, rdat);
    end
    $display("test erase done");
    for (int i = 0; i < 6; i++) begin
      ad = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'(1 + $urandom % 4094);
      dt = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      if (i == 0) d0 = dt;
      prog.op(flash_lock_pkg::MODE_WRITE_CODE, ad, dt, 1'b1, n, poll);
      chk1(1'b1, n >= WC - 1 && n <= WC + 1);
      chk1(~dt[7], poll[7]);
      prog.rd(flash_lock_pkg::MODE_READ_CODE, ad, rdat);
      chk8(dt, rdat);
      chk1(1'b0, oe_n);
    end
    prog.op(flash_lock_pkg::MODE_WRITE_CODE, 12'h000, ~d0, 1'b0, n, poll);
    chk1(1'b1, n == 0);
    prog.rd(flash_lock_pkg::MODE_READ_CODE, 12'h000, rdat);
    chk8(d0, rdat);
    for (int i = 0; i < 4; i++) begin
      prog.rd(flash_lock_pkg::MODE_READ_SIG, 12'(i << 8), rdat);
      chk8((i < 3) ? SIG[i] : 8'hFF, rdat);
    end
    $display("test program done");
    reg_write(flash_lock_pkg::REG_RADDR, 32'h0FFF);
    reg_read(flash_lock_pkg::REG_RADDR, w);
    chk32(32'h0FFF, w);
    reg_read(flash_lock_pkg::REG_RDATA, w);
    chk32(32'h80, w);
    reg_read(8'h10, w);
    chk32(32'h0, w);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      prog.op(fm[k], 12'h000, 8'h00, 1'b1, n, poll);
      chk1(1'b1, n >= WC - 1 && n <= WC + 1);
      le = lock_exp(k);
      prog.rd(flash_lock_pkg::MODE_READ_FUSES, 12'h000, rdat);
      chk8({3'h0, le[2:0], 2'h0}, rdat);
      reg_read(flash_lock_pkg::REG_STATUS, w);
      chk8({3'h0, le}, {3'h0, w[6:2]});
      chk1(1'b1, tblk);
      chk1(k == 2, xblk);
      prog.rd(flash_lock_pkg::MODE_READ_CODE, 12'h000, rdat);
      chk8(8'hFF, rdat);
      prog.op(flash_lock_pkg::MODE_WRITE_CODE, 12'h000, 8'h55, 1'b1, n, poll);
      chk1(1'b1, n == 0);
    end
    ea <= 1'b1;
    do_reset();
    chk1(1'b1, ea_eff);
    ea <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    chk1(1'b1, ea_eff);
    $display("test locks done");
    reg_write(flash_lock_pkg::REG_CTRL, 32'h1);
    reg_read(flash_lock_pkg::REG_STATUS, w);
    chk1(1'b1, w[1]);
    reg_read(flash_lock_pkg::REG_RDATA, w);
    chk32(32'h0, w);
    chk1(1'b0, busy);
    n = 0;
    while (!busy && n < EC + 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk1(1'b1, busy);
    prog.rd(flash_lock_pkg::MODE_READ_FUSES, 12'h000, rdat);
    chk8(8'h00, rdat);
    chk1(1'b0, tblk);
    $display("test register erase done");
    final_report();
  end
endmodule
